// ### verilog/hbfd_core.sv
// Fault aggregation and over-current classification of the H-bridge driver
//
// Contract
// [R1] Global fail low on any listed fault
// [R2] Fail releases only when all causes cleared
// [R3] Thermal shutdown fail held until disable toggled
// [R4] Supply undervoltage never counts as failure
// [R5] Global fail: 0 failure, 1 default
// [R6] Two-bit codes 10, 00, 11; never 01
// [R7] Four status fields returned on answer frame
// [R8] Window timer starts on every activation
// [R9] Blanking timer starts above on-current threshold
// [R10] Thresholds need confirmation time
// [R11] Over-current during timers gives 00
// [R12] Mid current or window incomplete gives 10
// [R13] Diagonal over-current while above threshold gives 11
// [R14] Late over-current still switches transistor off
// [R15] Event counter counts over-current after timers
// [R16] Counter cleared on disable fall or read
// [R17] Window code maps 9 to 45 microseconds
// [R18] Host writes window code in frame 3
// [R19] Window code echoed, default 111
// [R20] Status cleared by reset, enable, or read
// [R21] Only higher priority overwrites stored status
// [R22] Status latched, power-on value 10
// [R23] Blanking length chosen from supply band
`timescale 1ns/1ps
module hbfd_core #(
  parameter int N_FET = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  // Comparator levels per transistor: 0=hs0,1=ls0,2=hs1,3=ls1
  input wire logic [N_FET-1:0] oc_raw,
  input wire logic [N_FET-1:0] on_raw,
  input wire logic pwm_in,
  input wire logic direct_input_a,
  input wire logic direct_input_b,
  input wire logic [1:0] supply_band,
  input wire logic disable_in,
  input wire logic disable_in_n,
  input wire logic ol_on_fail,
  input wire logic off_diag_fail,
  input wire logic hardware_selfcheck_ok,
  input wire logic comm_check_latch,
  input wire logic vdd_ov_latched,
  input wire logic vdd_uv_latched,
  input wire logic vps_uv,
  input wire logic thermal_shutdown_latched,
  input wire logic undervolt_count_hit,
  input wire logic undervolt_count_stop,
  input wire logic [2:0] win_code_wr,
  input wire logic win_code_we,
  input wire logic clear_on_read_enable,
  input wire logic diag_read,
  input wire logic count_read,
  output logic global_fail_n,
  output logic [1:0] hs_overcurrent_out0,
  output logic [1:0] ls_overcurrent_out0,
  output logic [1:0] hs_overcurrent_out1,
  output logic [1:0] ls_overcurrent_out1,
  output logic [2:0] diag_window_echo,
  output logic [3:0] overcurrent_event_count,
  output logic [N_FET-1:0] fet_off
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] prio(input logic [1:0] c);
    prio = (c == hbfd_pkg::OC_DETECT) ? 2'h3 : (c == hbfd_pkg::OC_SHORT) ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [hbfd_pkg::TMR_W-1:0] win_cyc(input logic [2:0] c);
    int us;
    us = hbfd_pkg::WIN_US_0;
    case (c)
      3'h0: us = hbfd_pkg::WIN_US_0;
      3'h1: us = hbfd_pkg::WIN_US_1;
      3'h2: us = hbfd_pkg::WIN_US_2;
      3'h3: us = hbfd_pkg::WIN_US_3;
      3'h4: us = hbfd_pkg::WIN_US_4;
      3'h5: us = hbfd_pkg::WIN_US_5;
      3'h6: us = hbfd_pkg::WIN_US_6;
      default: us = hbfd_pkg::WIN_US_7;
    endcase
    win_cyc = hbfd_pkg::TMR_W'(us * hbfd_pkg::CLK_MHZ);
  endfunction

  // ----------------------------------------
  // Activation and window timer
  // ----------------------------------------
  logic pwm_q;
  logic diff_q;
  logic dis_q;
  logic [2:0] win_code;
  logic [hbfd_pkg::TMR_W-1:0] win_tmr;
  wire diff_now = direct_input_a ^ direct_input_b;
  wire activate = (pwm_in != pwm_q) | (diff_now & ~diff_q);
  wire dis_enable = dis_q & ~disable_in;
  // Status clear: enable edge or clearing read
  wire stat_clr = dis_enable | (diag_read & clear_on_read_enable); // [R20]
  wire win_run = win_tmr != '0;
  wire [hbfd_pkg::TMR_W-1:0] blank_len = (supply_band == 2'h0) ? hbfd_pkg::TMR_W'(hbfd_pkg::BLANK_CYC_LOW) :
    (supply_band == 2'h1) ? hbfd_pkg::TMR_W'(hbfd_pkg::BLANK_CYC_NORM) : hbfd_pkg::TMR_W'(hbfd_pkg::BLANK_CYC_HIGH);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwm_q <= 1'b0;
      diff_q <= 1'b0;
      dis_q <= 1'b0;
    end else begin
      pwm_q <= pwm_in;
      diff_q <= diff_now;
      dis_q <= disable_in;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      win_code <= hbfd_pkg::WIN_RESET;
    end else if (win_code_we) begin
      win_code <= win_code_wr; // [R18]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      win_tmr <= '0;
    end else if (activate) begin
      win_tmr <= win_cyc(win_code); // [R8] [R17]
    end else if (win_run) begin
      win_tmr <= win_tmr - 1'b1;
    end
  end

  // ----------------------------------------
  // Per-transistor confirmation and classification
  // ----------------------------------------
  logic [N_FET-1:0] oc_conf;
  logic [N_FET-1:0] on_conf;
  logic [N_FET-1:0] blank_run;
  logic [N_FET-1:0] timers_on;
  logic [1:0] stat [N_FET];
  logic [N_FET-1:0] late_oc;

  genvar g;
  generate
    for (g = 0; g < N_FET; g++) begin : g_fet
      logic [7:0] oc_cnt;
      logic [7:0] on_cnt;
      logic on_q;
      logic [hbfd_pkg::TMR_W-1:0] blank_tmr;
      logic [1:0] next_stat;
      logic [1:0] result;
      wire diag_conf = oc_conf[g ^ 3]; // diagonal partner
      assign oc_conf[g] = oc_cnt == 8'(hbfd_pkg::OC_CONFIRM_CYC); // [R10]
      assign on_conf[g] = on_cnt == 8'(hbfd_pkg::ON_CONFIRM_CYC); // [R10]
      assign blank_run[g] = blank_tmr != '0;
      assign timers_on[g] = win_run | blank_run[g];
      assign result = oc_conf[g] ? hbfd_pkg::OC_DETECT : // [R11]
        (on_conf[g] & diag_conf) ? hbfd_pkg::OC_SHORT : hbfd_pkg::OC_NONE; // [R13] [R12]
      assign next_stat = (timers_on[g] && prio(result) > prio(stat[g])) ? result : stat[g]; // [R21]
      // Result arriving with a clear survives it
      wire [1:0] fresh = timers_on[g] ? result : hbfd_pkg::OC_NONE; // [R20]
      assign late_oc[g] = oc_conf[g] & ~timers_on[g] & ~fet_off[g];

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          oc_cnt <= '0;
          on_cnt <= '0;
          on_q <= 1'b0;
        end else begin
          oc_cnt <= !oc_raw[g] ? 8'h00 : oc_conf[g] ? oc_cnt : oc_cnt + 8'h01;
          on_cnt <= !on_raw[g] ? 8'h00 : on_conf[g] ? on_cnt : on_cnt + 8'h01;
          on_q <= on_conf[g];
        end
      end

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          blank_tmr <= '0;
        end else if (on_conf[g] & ~on_q) begin
          blank_tmr <= blank_len; // [R9] [R23]
        end else if (blank_run[g]) begin
          blank_tmr <= blank_tmr - 1'b1;
        end
      end

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          stat[g] <= hbfd_pkg::OC_NONE; // [R22]
        end else if (stat_clr) begin
          stat[g] <= fresh; // [R20]
        end else begin
          stat[g] <= next_stat; // [R6]
        end
      end

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          fet_off[g] <= 1'b0;
        end else if (oc_conf[g]) begin
          fet_off[g] <= 1'b1; // [R14]
        end else if (dis_enable) begin
          fet_off[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Event counter
  // ----------------------------------------
  logic oc_seen;
  wire any_late = |late_oc;
  wire cnt_clr = (oc_seen & dis_q & ~disable_in) | count_read; // [R16]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      overcurrent_event_count <= hbfd_pkg::CNT_RESET;
      oc_seen <= 1'b0;
    end else begin
      if (any_late) begin
        overcurrent_event_count <= overcurrent_event_count + 4'h1; // [R15]
      end else if (cnt_clr) begin
        overcurrent_event_count <= hbfd_pkg::CNT_RESET;
      end
      oc_seen <= any_late | (oc_seen & ~cnt_clr);
    end
  end

  // ----------------------------------------
  // Global fail
  // ----------------------------------------
  logic tsd_hold;
  logic [N_FET-1:0] oc_fault;
  generate
    for (g = 0; g < N_FET; g++) begin : g_flt
      assign oc_fault[g] = stat[g] != hbfd_pkg::OC_NONE;
    end
  endgenerate
  // Supply undervoltage deliberately absent
  wire any_fail = (|oc_fault) | ol_on_fail | off_diag_fail | ~hardware_selfcheck_ok | comm_check_latch |
    vdd_ov_latched | vdd_uv_latched | tsd_hold | (undervolt_count_hit & undervolt_count_stop) |
    ~disable_in_n; // [R1] [R4]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tsd_hold <= 1'b0;
    end else if (thermal_shutdown_latched) begin
      tsd_hold <= 1'b1; // [R3]
    end else if (disable_in != dis_q) begin
      tsd_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      global_fail_n <= 1'b1; // [R5]
      hs_overcurrent_out0 <= hbfd_pkg::OC_NONE;
      ls_overcurrent_out0 <= hbfd_pkg::OC_NONE;
      hs_overcurrent_out1 <= hbfd_pkg::OC_NONE;
      ls_overcurrent_out1 <= hbfd_pkg::OC_NONE;
      diag_window_echo <= hbfd_pkg::WIN_RESET;
    end else begin
      global_fail_n <= ~any_fail; // [R2]
      hs_overcurrent_out0 <= stat[0]; // [R7]
      ls_overcurrent_out0 <= stat[1];
      hs_overcurrent_out1 <= stat[2];
      ls_overcurrent_out1 <= stat[3];
      diag_window_echo <= win_code; // [R19]
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_NO_01: assert property (@(posedge clk_sys) disable iff (reset) hs_overcurrent_out0 != 2'h1 // [R6]
    && ls_overcurrent_out0 != 2'h1 && hs_overcurrent_out1 != 2'h1 && ls_overcurrent_out1 != 2'h1)
    else $error("illegal status code 01");
  AST_FAIL_OC: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    (hs_overcurrent_out0 == 2'h0) |-> !global_fail_n) else $error("over-current not flagged");
  AST_DISN: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    !disable_in_n |=> !global_fail_n) else $error("disable low not flagged");
  AST_TSD: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    (tsd_hold && disable_in == $past(disable_in)) |=> !global_fail_n) else $error("thermal fail released early");
  AST_OC_SET: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
    (oc_conf[0] && timers_on[0] && !dis_enable && !(diag_read && clear_on_read_enable)) |=> ##1 hs_overcurrent_out0 == 2'h0)
    else $error("over-current not recorded");
  AST_PRIO: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    (stat[0] == 2'h0 && !dis_enable && !(diag_read && clear_on_read_enable)) |=> stat[0] == 2'h0)
    else $error("status overwritten by lower priority");
  AST_CLR: assert property (@(posedge clk_sys) disable iff (reset) // [R20]
    (diag_read && clear_on_read_enable && g_fet[0].fresh == 2'h2) |=> ##1 hs_overcurrent_out0 == 2'h2)
    else $error("read clear failed");
  AST_CNT: assert property (@(posedge clk_sys) disable iff (reset) // [R15]
    (any_late && overcurrent_event_count != 4'hF) |=> overcurrent_event_count == $past(overcurrent_event_count) + 4'h1)
    else $error("event count not incremented");
  AST_WIN: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    activate |=> win_tmr == win_cyc($past(win_code))) else $error("window timer not started");
  AST_ECHO: assert property (@(posedge clk_sys) disable iff (reset) // [R19]
    win_code_we |=> ##1 diag_window_echo == $past(win_code_wr, 2)) else $error("window echo wrong");

  // Classification, storage, global fail and switch-off
  AST_SHORT: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
    (on_conf[0] && oc_conf[3] && !oc_conf[0] && timers_on[0] && stat[0] == 2'h2) |=> stat[0] == 2'h3)
    else $error("diagonal short not recorded");
  AST_NO_STORE: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
    (!timers_on[1] && stat[1] == 2'h2) |=> stat[1] == 2'h2)
    else $error("result stored outside the timers");
  AST_SHORT_KEEP: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    (stat[0] == 2'h3 && !stat_clr) |=> stat[0] != 2'h2)
    else $error("short overwritten by lower priority");
  AST_FAIL_LS1: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    (ls_overcurrent_out1 != 2'h2) |-> !global_fail_n) else $error("ls1 status not flagged");
  AST_FET_OFF: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
    oc_conf[1] |=> fet_off[1]) else $error("transistor not switched off");
  AST_DIS_REL: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
    (dis_enable && !oc_conf[0]) |=> !fet_off[0])
    else $error("transistor not released by enable");

  // Counter, timers and fail hold
  AST_CNT_CLR: assert property (@(posedge clk_sys) disable iff (reset) // [R16]
    (count_read && !any_late) |=> overcurrent_event_count == 4'h0)
    else $error("event count not cleared by read");
  AST_BLANK: assert property (@(posedge clk_sys) disable iff (reset) // [R9] [R23]
    (on_conf[3] && !g_fet[3].on_q) |=> g_fet[3].blank_tmr == $past(blank_len))
    else $error("blanking timer not started");
  AST_WIN_DEC: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    (win_run && !activate) |=> win_tmr == $past(win_tmr) - 1'b1)
    else $error("window timer not counting down");
  AST_TSD_SET: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    thermal_shutdown_latched |=> tsd_hold) else $error("thermal hold not set");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  COV_OC: cover property (@(posedge clk_sys) disable iff (reset) hs_overcurrent_out0 == 2'h0);
  COV_SHORT: cover property (@(posedge clk_sys) disable iff (reset) ls_overcurrent_out1 == 2'h3);
  COV_LATE: cover property (@(posedge clk_sys) disable iff (reset) any_late);
  COV_TSD: cover property (@(posedge clk_sys) disable iff (reset) tsd_hold ##1 !tsd_hold);
  COV_BLANK: cover property (@(posedge clk_sys) disable iff (reset) !win_run && blank_run[2] && oc_conf[2]);

endmodule // hbfd_core

// ### verilog/hbfd_pkg.sv
// Constants of the H-bridge fault diagnostic logic
package hbfd_pkg;
  // Over-current status codes
  localparam logic [1:0] OC_NONE = 2'h2;
  localparam logic [1:0] OC_DETECT = 2'h0;
  localparam logic [1:0] OC_SHORT = 2'h3;
  localparam logic [2:0] WIN_RESET = 3'h7;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int CLK_MHZ = 250;
  // Window lengths in microseconds, index = code
  localparam int WIN_US_0 = 9;
  localparam int WIN_US_1 = 14;
  localparam int WIN_US_2 = 20;
  localparam int WIN_US_3 = 25;
  localparam int WIN_US_4 = 30;
  localparam int WIN_US_5 = 35;
  localparam int WIN_US_6 = 40;
  localparam int WIN_US_7 = 45;
  // Blanking time per supply band, microseconds
  localparam int BLANK_US_LOW = 10;
  localparam int BLANK_US_NORM = 20;
  localparam int BLANK_US_HIGH = 30;
  // Confirmation times, nanoseconds
  localparam int OC_CONFIRM_NS = 1000;
  localparam int ON_CONFIRM_NS = 1000;
  localparam int OC_CONFIRM_CYC = (OC_CONFIRM_NS * CLK_MHZ + 999) / 1000;
  localparam int ON_CONFIRM_CYC = (ON_CONFIRM_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC_LOW = BLANK_US_LOW * CLK_MHZ;
  localparam int BLANK_CYC_NORM = BLANK_US_NORM * CLK_MHZ;
  localparam int BLANK_CYC_HIGH = BLANK_US_HIGH * CLK_MHZ;
  localparam int TMR_W = 14;
endpackage

// ### verif/hbfd_host.sv
// Microcontroller model: disable pins, window writes, reads, activations
`timescale 1ns/1ps
module hbfd_host (
  input wire logic clk_sys,
  output logic disable_in,
  output logic disable_in_n,
  output logic pwm_in,
  output logic [2:0] win_code_wr,
  output logic win_code_we,
  output logic clear_on_read_enable,
  output logic diag_read,
  output logic count_read
);
  initial begin
    disable_in = 1'b0;
    disable_in_n = 1'b1;
    pwm_in = 1'b0;
    win_code_wr = 3'h7;
    win_code_we = 1'b0;
    clear_on_read_enable = 1'b1;
    diag_read = 1'b0;
    count_read = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic write_window(input logic [2:0] c);
    win_code_wr = c;
    win_code_we = 1'b1;
    step(1);
    win_code_we = 1'b0;
  endtask

  task automatic toggle_disable();
    disable_in = 1'b1;
    step(2);
    disable_in = 1'b0;
    step(1);
  endtask

  task automatic read_diag();
    diag_read = 1'b1;
    step(1);
    diag_read = 1'b0;
  endtask

  task automatic read_count();
    count_read = 1'b1;
    step(1);
    count_read = 1'b0;
  endtask

  task automatic activate();
    pwm_in = ~pwm_in;
    step(1);
  endtask
endmodule // hbfd_host

// ### verif/hbfd_core_bench.sv
// Self-checking bench of the fault diagnostic core
`timescale 1ns/1ps
module hbfd_core_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] oc_raw = 4'h0;
  logic [7:0] flt = 8'h00;
  logic vps_uv = 1'b0;
  logic di_a = 1'b0;
  logic di_b = 1'b0;
  logic [3:0] on_raw = 4'h0;
  logic [1:0] band = 2'h1;
  wire disable_in, disable_in_n, pwm_in, win_code_we, clr_en, diag_read, count_read;
  wire [2:0] win_code_wr;
  wire global_fail_n;
  wire [1:0] hs0, ls0, hs1, ls1;
  wire [2:0] echo;
  wire [3:0] cnt, fet_off;
  int n_errors = 0;
  int n_tests = 0;

  always #2 clk_sys = ~clk_sys;

  hbfd_host HOST (.clk_sys(clk_sys), .disable_in(disable_in), .disable_in_n(disable_in_n), .pwm_in(pwm_in),
    .win_code_wr(win_code_wr), .win_code_we(win_code_we), .clear_on_read_enable(clr_en),
    .diag_read(diag_read), .count_read(count_read));

  hbfd_core DUT (.clk_sys(clk_sys), .reset(reset), .oc_raw(oc_raw), .on_raw(on_raw), .pwm_in(pwm_in),
    .direct_input_a(di_a), .direct_input_b(di_b), .supply_band(band), .disable_in(disable_in),
    .disable_in_n(disable_in_n), .ol_on_fail(flt[0]), .off_diag_fail(flt[1]), .hardware_selfcheck_ok(~flt[2]),
    .comm_check_latch(flt[3]), .vdd_ov_latched(flt[4]), .vdd_uv_latched(flt[5]), .vps_uv(vps_uv),
    .thermal_shutdown_latched(flt[6]), .undervolt_count_hit(flt[7]), .undervolt_count_stop(flt[7]),
    .win_code_wr(win_code_wr), .win_code_we(win_code_we), .clear_on_read_enable(clr_en),
    .diag_read(diag_read), .count_read(count_read), .global_fail_n(global_fail_n),
    .hs_overcurrent_out0(hs0), .ls_overcurrent_out0(ls0), .hs_overcurrent_out1(hs1),
    .ls_overcurrent_out1(ls1), .diag_window_echo(echo), .overcurrent_event_count(cnt), .fet_off(fet_off));

  // ---------------------------------------
  // Shared tasks
  // ---------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_codes(input logic [1:0] exp);
    chk({2'h0, hs0}, {2'h0, exp});
    chk({2'h0, ls0}, {2'h0, exp});
    chk({2'h0, hs1}, {2'h0, exp});
    chk({2'h0, ls1}, {2'h0, exp});
  endtask

  // ---------------------------------------
  // Scenarios
  // ---------------------------------------
  task automatic t_reset();
    chk_codes(hbfd_pkg::OC_NONE);
    chk({1'b0, echo}, {1'b0, hbfd_pkg::WIN_RESET});
    chk(cnt, hbfd_pkg::CNT_RESET);
    chk({3'h0, global_fail_n}, 4'h1);
  endtask

  task automatic t_window();
    for (int i = 7; i >= 0; i--) begin
      HOST.write_window(3'(i));
      HOST.step(2);
      chk({1'b0, echo}, 4'(i));
    end
  endtask

  task automatic t_faults();
    for (int i = 0; i < 8; i++) begin
      flt = 8'(1 << i);
      HOST.step(3);
      chk({3'h0, global_fail_n}, 4'h0);
      flt = 8'h00;
      HOST.step(3);
      chk({3'h0, global_fail_n}, {3'h0, i != 6});
      if (i == 6) begin
        HOST.toggle_disable();
        HOST.step(2);
        chk({3'h0, global_fail_n}, 4'h1);
      end
    end
    HOST.disable_in_n = 1'b0;
    HOST.step(3);
    chk({3'h0, global_fail_n}, 4'h0);
    HOST.disable_in_n = 1'b1;
    vps_uv = 1'b1;
    HOST.step(3);
    chk({3'h0, global_fail_n}, 4'h1);
    vps_uv = 1'b0;
  endtask

  task automatic t_oc_window();
    HOST.activate();
    oc_raw = 4'h1;
    HOST.step(hbfd_pkg::OC_CONFIRM_CYC + 6);
    chk({2'h0, hs0}, {2'h0, hbfd_pkg::OC_DETECT});
    chk({2'h0, ls0}, {2'h0, hbfd_pkg::OC_NONE});
    chk({3'h0, global_fail_n}, 4'h0);
    chk(cnt, 4'h0);
    oc_raw = 4'h0;
    HOST.step(4);
    chk({2'h0, hs0}, {2'h0, hbfd_pkg::OC_DETECT});
    HOST.read_diag();
    HOST.step(3);
    chk_codes(hbfd_pkg::OC_NONE);
  endtask

  task automatic t_oc_late();
    HOST.toggle_disable();
    HOST.step(hbfd_pkg::WIN_US_0 * hbfd_pkg::CLK_MHZ + 300);
    oc_raw = 4'h2;
    HOST.step(hbfd_pkg::OC_CONFIRM_CYC + 6);
    chk({3'h0, fet_off[1]}, 4'h1);
    chk(cnt, 4'h1);
    chk({2'h0, ls0}, {2'h0, hbfd_pkg::OC_NONE});
    oc_raw = 4'h0;
    HOST.toggle_disable();
    HOST.step(2);
    chk(cnt, 4'h0);
  endtask

  task automatic t_blank();
    on_raw = 4'h4;
    HOST.step(hbfd_pkg::ON_CONFIRM_CYC + 10);
    oc_raw = 4'h4;
    HOST.step(hbfd_pkg::OC_CONFIRM_CYC + 6);
    chk({2'h0, hs1}, {2'h0, hbfd_pkg::OC_DETECT});
    chk(cnt, 4'h0);
    oc_raw = 4'h0;
    on_raw = 4'h0;
    HOST.toggle_disable();
    band = 2'h0;
    on_raw = 4'h8;
    HOST.step(hbfd_pkg::ON_CONFIRM_CYC + hbfd_pkg::BLANK_CYC_LOW + 20);
    oc_raw = 4'h8;
    HOST.step(hbfd_pkg::OC_CONFIRM_CYC + 6);
    chk({2'h0, ls1}, {2'h0, hbfd_pkg::OC_NONE});
    chk(cnt, 4'h1);
    chk({3'h0, fet_off[3]}, 4'h1);
  endtask

  task automatic t_short();
    oc_raw = 4'h0;
    on_raw = 4'h0;
    HOST.read_count();
    HOST.step(1);
    chk(cnt, 4'h0);
    HOST.toggle_disable();
    di_a = 1'b1;
    on_raw = 4'h1;
    oc_raw = 4'h8;
    HOST.step(hbfd_pkg::OC_CONFIRM_CYC + 6);
    chk({2'h0, hs0}, {2'h0, hbfd_pkg::OC_SHORT});
    chk({2'h0, ls1}, {2'h0, hbfd_pkg::OC_DETECT});
    chk({3'h0, global_fail_n}, 4'h0);
    oc_raw = 4'h0;
    on_raw = 4'h0;
    HOST.clear_on_read_enable = 1'b0;
    HOST.read_diag();
    HOST.step(3);
    chk({2'h0, hs0}, {2'h0, hbfd_pkg::OC_SHORT});
    HOST.clear_on_read_enable = 1'b1;
    HOST.read_diag();
    HOST.step(3);
    chk_codes(hbfd_pkg::OC_NONE);
  endtask

  initial begin
    #240000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    HOST.step(2);
    t_reset();
    t_window();
    t_faults();
    t_oc_window();
    t_oc_late();
    t_blank();
    t_short();
    stop_test();
  end
endmodule // hbfd_core_bench
